/* bml_eprom_model.sv */
// Byte-wide boot EPROM on the external bus.
// Assumes an active-low select and read strobe, byte on data 23:16.
`timescale 1ns/1ps
`default_nettype none
module bml_eprom_model (
    input wire logic clk,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic [31:0] addr,
    output logic [31:0] data
);
    logic [7:0] last = 8'h00;
    logic [7:0] rom_byte;
    assign rom_byte = addr[7:0] ^ {5'h00, addr[10:8]};
    always @(posedge clk) begin
        if (!cs_n && !rd_n) begin
            last <= rom_byte;
        end
    end
    // outputs enabled only while selected and strobed
    // Released bus shows the inverse, so a stale byte cannot pass
    assign data = (!cs_n && !rd_n) ? {8'h00, rom_byte, 16'h0000} : {8'hFF, ~last, 16'hFFFF};
endmodule
`default_nettype wire

/* bml_loader.sv */
// Boot-mode strap decoder and byte-wide boot loader with an 8-word FIFO.
// Assumes straps are hardwired, external bus pins are sampled on clk, and
// the internal memory side accepts words with valid/ready.
`timescale 1ns/1ps
`default_nettype none

module bml_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; emptiness is carried by the count alone
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule

module bml_loader
    import bml_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic eprom_boot_select,
    input wire logic link_host_boot_select,
    input wire logic boot_memory_select_in,
    output logic boot_memory_select_n_out,
    output logic boot_memory_select_oe,
    input wire logic bus_master,
    input wire logic ack_in,
    output logic ack_out,
    output logic ack_oe,
    input wire logic [31:0] data_in,
    output logic [31:0] addr_out,
    output logic rd_n,
    output logic normal_selects_enable,
    input wire logic [1:0] unbanked_wait_mode_wr,
    input wire logic unbanked_wait_mode_we,
    output logic [2:0] boot_mode,
    output logic [15:0] boot_channel_control,
    output logic [15:0] boot_word_count,
    output logic [15:0] external_byte_count,
    output logic [31:0] internal_index,
    output logic [3:0] unbanked_wait_states,
    output logic [1:0] unbanked_wait_mode,
    output logic [31:0] program_counter,
    output logic boot_channel_interrupt,
    output logic mem_valid,
    input wire logic mem_ready,
    output logic [47:0] mem_data,
    output logic [31:0] mem_addr
);
    logic [2:0] eb_sync, lb_sync, bm_sync, ack_sync, fill_reg;
    bml_mode_e mode_reg, mode_next;
    bml_state_e st_reg, st_next;
    logic cs_reg, cs_next, rd_reg, rd_next, irq_reg, irq_next;
    logic [3:0] wait_reg, wait_next, occ_reg, occ_next;
    logic [2:0] lane_reg, lane_next;
    logic [47:0] pack_reg, pack_next;
    logic [15:0] ctrl_reg, ctrl_next, wc_reg, wc_next, bc_reg, bc_next;
    logic [31:0] ii_reg, ii_next, ei_reg, ei_next, pc_reg, pc_next;
    logic [3:0] unbanked_wait_states_reg, unbanked_wait_states_next;
    logic [1:0] unbanked_wait_mode_reg, unbanked_wait_mode_next;
    logic nsel_reg, nsel_next;
    logic push_valid, push_ready;
    logic ack_ok;

    // Three-stage strap and acknowledge sampling; stage 0 feeds stage 1 only.
    // fill_reg keeps the decode off the stages' reset values after release.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            eb_sync <= '0;
            lb_sync <= '0;
            bm_sync <= 3'h7;
            ack_sync <= 3'h7;
            fill_reg <= '0;
        end else begin
            eb_sync <= {eb_sync[1:0], eprom_boot_select};
            lb_sync <= {lb_sync[1:0], link_host_boot_select};
            bm_sync <= {bm_sync[1:0], boot_memory_select_in};
            ack_sync <= {ack_sync[1:0], ack_in};
            fill_reg <= {fill_reg[1:0], 1'b1};
        end
    end

    assign ack_ok = (unbanked_wait_mode_reg == BML_WAIT_MODE_INTERNAL)
                    || (ack_sync[1] && ack_sync[2]);
    assign ack_out = 1'b1;
    assign ack_oe = !reset_n;

    bml_fifo #(.WIDTH(BML_WORD_W), .DEPTH(BML_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(pack_next),
        .out_valid(mem_valid),
        .out_ready(mem_ready),
        .out_data(mem_data)
    );

    always_comb begin
        mode_next = mode_reg;
        st_next = st_reg;
        cs_next = cs_reg;
        rd_next = rd_reg;
        irq_next = 1'b0;
        wait_next = wait_reg;
        lane_next = lane_reg;
        pack_next = pack_reg;
        ctrl_next = ctrl_reg;
        wc_next = wc_reg;
        bc_next = bc_reg;
        ii_next = ii_reg;
        ei_next = ei_reg;
        pc_next = pc_reg;
        unbanked_wait_states_next = unbanked_wait_states_reg;
        unbanked_wait_mode_next = unbanked_wait_mode_reg;
        nsel_next = nsel_reg;
        push_valid = 1'b0;
        if (unbanked_wait_mode_we) begin
            unbanked_wait_mode_next = unbanked_wait_mode_wr;
        end
        case (st_reg)
            BML_ST_RESET: begin
                if (fill_reg[2] && eb_sync[2] == eb_sync[1] && lb_sync[2] == lb_sync[1]
                    && bm_sync[2] == bm_sync[1]) begin
                    if (eb_sync[2]) begin
                        mode_next = BML_MODE_EPROM;
                    end else if (!bm_sync[2]) begin
                        mode_next = lb_sync[2] ? BML_MODE_RSVD : BML_MODE_NONE;
                    end else begin
                        mode_next = lb_sync[2] ? BML_MODE_LINK : BML_MODE_HOST;
                    end
                    pc_next = BML_IDLE_PC;
                    st_next = eb_sync[2] ? BML_ST_INIT : BML_ST_IDLE;
                end
            end
            BML_ST_INIT: begin
                ctrl_next = BML_CTRL_INIT;
                wc_next = BML_WORD_COUNT_INIT;
                bc_next = BML_BYTE_COUNT_INIT;
                ii_next = BML_INT_INDEX_INIT;
                ei_next = BML_EXT_INDEX_INIT;
                unbanked_wait_states_next = BML_WAIT_STATES_INIT;
                nsel_next = 1'b0;
                st_next = BML_ST_READ;
            end
            BML_ST_READ: begin
                if (bus_master) begin
                    cs_next = 1'b1;
                    rd_next = 1'b1;
                    wait_next = unbanked_wait_states_reg;
                    st_next = BML_ST_WAIT;
                end
            end
            BML_ST_WAIT: begin
                if (wait_reg != '0) begin
                    wait_next = wait_reg - 1'b1;
                end else if (ack_ok) begin
                    cs_next = 1'b0;
                    rd_next = 1'b0;
                    pack_next[lane_reg*BML_BYTE_W +: BML_BYTE_W] =
                        data_in[BML_DATA_LSB +: BML_BYTE_W];
                    bc_next = bc_reg - 1'b1;
                    ei_next = ei_reg + BML_INDEX_STEP;
                    if (lane_reg == BML_LAST_LANE) begin
                        lane_next = '0;
                        st_next = BML_ST_DRAIN;
                    end else begin
                        lane_next = lane_reg + 1'b1;
                        st_next = BML_ST_READ;
                    end
                end
            end
            BML_ST_DRAIN: begin
                push_valid = 1'b1;
                if (push_ready) begin
                    wc_next = wc_reg - 1'b1;
                    ii_next = ii_reg + BML_INDEX_STEP;
                    st_next = (bc_reg == '0) ? BML_ST_DONE : BML_ST_READ;
                end
            end
            BML_ST_DONE: begin
                // Waits for the last words to leave the FIFO before vectoring
                if (!mem_valid) begin
                    irq_next = 1'b1;
                    nsel_next = 1'b1;
                    pc_next = BML_VECTOR_PC;
                    st_next = BML_ST_IDLE;
                end
            end
            BML_ST_IDLE: begin
                nsel_next = 1'b1;
            end
            default: begin
                st_next = BML_ST_IDLE;
            end
        endcase
        occ_next = occ_reg + 4'(push_valid && push_ready) - 4'(mem_valid && mem_ready);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= BML_MODE_NONE;
            st_reg <= BML_ST_RESET;
            cs_reg <= 1'b0;
            rd_reg <= 1'b0;
            irq_reg <= 1'b0;
            wait_reg <= '0;
            lane_reg <= '0;
            pack_reg <= '0;
            ctrl_reg <= '0;
            wc_reg <= '0;
            bc_reg <= '0;
            ii_reg <= '0;
            ei_reg <= '0;
            pc_reg <= '0;
            unbanked_wait_states_reg <= BML_WAIT_STATES_INIT;
            unbanked_wait_mode_reg <= BML_WAIT_MODE_INIT;
            nsel_reg <= 1'b0;
            occ_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            st_reg <= st_next;
            cs_reg <= cs_next;
            rd_reg <= rd_next;
            irq_reg <= irq_next;
            wait_reg <= wait_next;
            lane_reg <= lane_next;
            pack_reg <= pack_next;
            ctrl_reg <= ctrl_next;
            wc_reg <= wc_next;
            bc_reg <= bc_next;
            ii_reg <= ii_next;
            ei_reg <= ei_next;
            pc_reg <= pc_next;
            unbanked_wait_states_reg <= unbanked_wait_states_next;
            unbanked_wait_mode_reg <= unbanked_wait_mode_next;
            nsel_reg <= nsel_next;
            occ_reg <= occ_next;
        end
    end

    // Drive only in EPROM mode as master
    assign boot_memory_select_oe = (mode_reg == BML_MODE_EPROM) && bus_master;
    assign boot_memory_select_n_out = !(cs_reg && bus_master);
    assign rd_n = !rd_reg;
    assign addr_out = ei_reg;
    assign normal_selects_enable = nsel_reg;
    assign boot_mode = mode_reg;
    assign boot_channel_control = ctrl_reg;
    assign boot_word_count = wc_reg;
    assign external_byte_count = bc_reg;
    assign internal_index = ii_reg;
    assign unbanked_wait_states = unbanked_wait_states_reg;
    assign unbanked_wait_mode = unbanked_wait_mode_reg;
    assign program_counter = pc_reg;
    assign boot_channel_interrupt = irq_reg;
    // FIFO holds data only; the head word's address is rebuilt from occupancy
    assign mem_addr = ii_reg - 32'(occ_reg);
endmodule

`default_nettype wire

/* bml_loader_props.sv */
// Port checker for the boot-mode decoder and byte-wide boot loader.
// Assumes it is bound onto bml_loader: one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bml_loader_props
    import bml_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bus_master,
    input wire logic ack_in,
    input wire logic ack_out,
    input wire logic ack_oe,
    input wire logic boot_memory_select_n_out,
    input wire logic boot_memory_select_oe,
    input wire logic [31:0] addr_out,
    input wire logic rd_n,
    input wire logic normal_selects_enable,
    input wire logic [2:0] boot_mode,
    input wire logic [15:0] external_byte_count,
    input wire logic [1:0] unbanked_wait_mode,
    input wire logic [31:0] program_counter,
    input wire logic boot_channel_interrupt
);
    sequence s_strobe;
        !rd_n[*7];
    endsequence
    sequence s_wake;
        program_counter == BML_VECTOR_PC && normal_selects_enable && boot_memory_select_n_out;
    endsequence
    // No disable here: this one is about the reset itself
    a_ack_reset_high: assert property (@(posedge clk) !reset_n |-> ack_oe && ack_out)
        else $error("ack not held high in reset");
    a_cs_needs_master: assert property (@(posedge clk) disable iff (!reset_n)
        !boot_memory_select_n_out |-> bus_master && boot_memory_select_oe)
        else $error("chip select without bus ownership");
    a_oe_eprom_only: assert property (@(posedge clk) disable iff (!reset_n)
        boot_memory_select_oe |-> boot_mode == BML_MODE_EPROM && bus_master)
        else $error("select pin driven outside eprom mode");
    a_strobe_seven: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(rd_n) |-> s_strobe)
        else $error("read strobe shorter than seven cycles");
    a_addr_step: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(rd_n) |-> addr_out == $past(addr_out) + 32'h0000_0001)
        else $error("address did not step by one");
    a_count_step: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(rd_n) |-> external_byte_count == $past(external_byte_count) - 16'h0001)
        else $error("byte count did not step down by one");
    a_ack_low_stall: assert property (@(posedge clk) disable iff (!reset_n)
        (unbanked_wait_mode == BML_WAIT_MODE_INIT && !ack_in)[*6] |-> !$rose(rd_n))
        else $error("access ended while ack low");
    a_irq_wake: assert property (@(posedge clk) disable iff (!reset_n)
        boot_channel_interrupt |-> external_byte_count == 16'h0000 ##[0:2] s_wake)
        else $error("wake-up sequence wrong");
    a_irq_one_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        boot_channel_interrupt |=> !boot_channel_interrupt)
        else $error("interrupt longer than one cycle");
    a_mode_held: assert property (@(posedge clk) disable iff (!reset_n)
        boot_mode != BML_MODE_NONE |=> $stable(boot_mode))
        else $error("boot mode changed after decode");
endmodule
`default_nettype wire

/* bml_pkg.sv */
// Package for the boot-mode selector and byte-wide boot loader.
// Assumes a single 25 MHz clock domain; imported by the loader, its checker and the testbench.
package bml_pkg;
    localparam int BML_BYTE_W = 8;
    localparam int BML_WORD_W = 48;
    localparam int BML_ADDR_W = 32;
    localparam int BML_FIFO_DEPTH = 8;
    localparam int BML_BYTES_PER_WORD = 6;
    localparam logic [15:0] BML_CTRL_INIT = 16'h02A1;
    localparam logic [15:0] BML_WORD_COUNT_INIT = 16'h0100;
    localparam logic [15:0] BML_BYTE_COUNT_INIT = 16'h0600;
    localparam logic [31:0] BML_INT_INDEX_INIT = 32'h0002_0000;
    localparam logic [31:0] BML_EXT_INDEX_INIT = 32'h0040_0000;
    localparam logic [31:0] BML_IDLE_PC = 32'h0002_0004;
    localparam logic [31:0] BML_VECTOR_PC = 32'h0002_0040;
    localparam logic [31:0] BML_INDEX_STEP = 32'h0000_0001;
    localparam logic [3:0] BML_WAIT_STATES_INIT = 4'h6;
    localparam logic [1:0] BML_WAIT_MODE_INIT = 2'h0;
    localparam logic [1:0] BML_WAIT_MODE_INTERNAL = 2'h1;
    localparam logic [2:0] BML_LAST_LANE = 3'h5;
    localparam int BML_DATA_LSB = 16;

    typedef enum logic [2:0] {
        BML_MODE_NONE = 3'b000,
        BML_MODE_EPROM = 3'b001,
        BML_MODE_HOST = 3'b010,
        BML_MODE_LINK = 3'b011,
        BML_MODE_RSVD = 3'b100
    } bml_mode_e;

    typedef enum logic [2:0] {
        BML_ST_RESET = 3'b000,
        BML_ST_INIT = 3'b001,
        BML_ST_READ = 3'b010,
        BML_ST_WAIT = 3'b011,
        BML_ST_DRAIN = 3'b100,
        BML_ST_DONE = 3'b101,
        BML_ST_IDLE = 3'b110
    } bml_state_e;
endpackage

/* testbench.sv */
// Self-checking bench for bml_loader with an EPROM model.
// Assumes a 25 MHz clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: %s", $time, m); end end
module testbench;
    import bml_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, bus_master = 1'b0, ack_drv = 1'b1, bms_strap = 1'b1;
    logic eprom_boot_select = 1'b1, link_host_boot_select = 1'b0;
    logic [1:0] unbanked_wait_mode_wr = 2'h0;
    logic unbanked_wait_mode_we = 1'b0, mem_ready = 1'b0;
    logic boot_memory_select_n_out, boot_memory_select_oe, ack_out, ack_oe, rd_n;
    logic normal_selects_enable, boot_channel_interrupt, mem_valid;
    logic [31:0] data_in, addr_out, internal_index, program_counter, mem_addr;
    logic [2:0] boot_mode;
    logic [15:0] boot_channel_control, boot_word_count, external_byte_count;
    logic [3:0] unbanked_wait_states;
    logic [1:0] unbanked_wait_mode;
    logic [47:0] mem_data;
    wire logic boot_memory_select_in;
    wire logic ack_in;
    wire logic cs_pin;
    int fail_count = 0, checked = 0, cycles = 0;
    // Pin levels resolved from the loader's output enables
    assign cs_pin = boot_memory_select_oe ? boot_memory_select_n_out : 1'b1;
    assign boot_memory_select_in = boot_memory_select_oe ? boot_memory_select_n_out : bms_strap;
    assign ack_in = ack_oe ? ack_out : ack_drv;
    bml_loader DUT (.*);
    bml_eprom_model rom (.clk(clk), .cs_n(cs_pin), .rd_n(rd_n), .addr(addr_out), .data(data_in));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            $display("wrong value at %0t: timeout", $time);
            results();
        end
    end
    task results;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task do_reset(input logic e, input logic l, input logic b);
        reset_n = 1'b0;
        {eprom_boot_select, link_host_boot_select, bms_strap} = {e, l, b};
        cyc(12);
        reset_n = 1'b1;
    endtask
    function automatic logic [47:0] exp_word(input int n);
        logic [31:0] a;
        for (int k = 0; k < 6; k++) begin
            a = BML_EXT_INDEX_INIT + 32'(6 * n + k);
            exp_word[8*k +: 8] = a[7:0] ^ {5'h00, a[10:8]};
        end
    endfunction
    task t_modes;
        logic [2:0] exp;
        bus_master = 1'b1;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2], i[1], i[0]);
            exp = i[2] ? BML_MODE_EPROM : i[1] ? (i[0] ? BML_MODE_LINK : BML_MODE_RSVD)
                : (i[0] ? BML_MODE_HOST : BML_MODE_NONE);
            cyc(8);
            // Straps move after release; decode must hold
            {eprom_boot_select, link_host_boot_select, bms_strap} = ~i[2:0];
            cyc(6);
            `CHK(boot_mode, exp, "boot mode")
            `CHK(boot_memory_select_oe, i[2], "select pin direction")
            `CHK(normal_selects_enable, !i[2], "memory selects")
        end
    endtask
    task t_regs;
        bus_master = 1'b0;
        reset_n = 1'b0;
        cyc(2);
        `CHK(ack_in, 1'b1, "ack in reset")
        do_reset(1'b1, 1'b0, 1'b0);
        cyc(12);
        `CHK(boot_channel_control, BML_CTRL_INIT, "control init")
        `CHK(boot_word_count, BML_WORD_COUNT_INIT, "word count")
        `CHK(external_byte_count, BML_BYTE_COUNT_INIT, "byte count")
        `CHK(internal_index, BML_INT_INDEX_INIT, "internal index")
        `CHK(addr_out, BML_EXT_INDEX_INIT, "eprom address")
        `CHK(unbanked_wait_states, BML_WAIT_STATES_INIT, "wait states")
        `CHK(unbanked_wait_mode, BML_WAIT_MODE_INIT, "wait mode")
        `CHK(program_counter, BML_IDLE_PC, "idle pc")
        `CHK(cs_pin, 1'b1, "select without ownership")
        `CHK(rd_n, 1'b1, "strobe without ownership")
    endtask
    task t_stall;
        ack_drv = 1'b0;
        bus_master = 1'b1;
        cyc(40);
        `CHK(external_byte_count, BML_BYTE_COUNT_INIT, "ack stall")
        `CHK(rd_n, 1'b0, "strobe held in stall")
        // boot program switches to internal wait only
        unbanked_wait_mode_wr = BML_WAIT_MODE_INTERNAL;
        unbanked_wait_mode_we = 1'b1;
        cyc(1);
        unbanked_wait_mode_we = 1'b0;
        cyc(4);
        `CHK(external_byte_count, 16'h05FF, "stall released")
        ack_drv = 1'b1;
    endtask
    task t_boot;
        int n;
        logic [15:0] held;
        logic done;
        n = 0;
        done = 1'b0;
        cyc(700);
        held = external_byte_count;
        cyc(20);
        `CHK(mem_valid, 1'b1, "full fifo offers word")
        `CHK(external_byte_count, held, "reads stop when fifo full")
        `CHK(program_counter, BML_IDLE_PC, "idle while loading")
        for (int t = 0; t < 16000 && !done; t++) begin
            mem_ready = (t % 4 != 3);
            #2;
            if (mem_valid && mem_ready) begin
                `CHK(mem_data, exp_word(n), "packed word")
                `CHK(mem_addr, BML_INT_INDEX_INIT + 32'(n), "word address")
                n++;
            end
            cyc(1);
            done = boot_channel_interrupt;
        end
        `CHK(done, 1'b1, "boot interrupt")
        `CHK(n, 256, "words loaded")
        `CHK(program_counter, BML_VECTOR_PC, "vector")
        `CHK(external_byte_count, 16'h0000, "byte count end")
        `CHK(addr_out, 32'h0040_0600, "final address")
        cyc(3);
        `CHK(normal_selects_enable, 1'b1, "selects back")
        `CHK(cs_pin, 1'b1, "boot select released")
    endtask
    initial begin
        t_modes();
        t_regs();
        t_stall();
        t_boot();
        results();
    end
endmodule
bind bml_loader bml_loader_props u_props (.*);
`default_nettype wire
